// ===== ssv_special_view.sv
// register view: notation string, special registers, reading, range, faults
//
// Functional notes
// RULE_01: the units code (PPM, PPB or two spaces and a percent) is followed by a space.
// RULE_02: the gas name after that space may be any ASCII characters.
// RULE_03: the notation string ends with a null character.
// RULE_04: text words carry the earlier character low and the next one high.
// RULE_05: the reading's unit is whatever the units field of the string names.
// RULE_06: the reading is the gas value times 1, 10 or 100 for low-range code 0, 1 or 2.
// RULE_07: the range register only ever holds 20, 50, 100 or 200.
// RULE_08: fault status bits follow their conditions and clear without any write.
// RULE_09: calibration-overdue rises after 180 days with no completed span calibration.
// RULE_10: the master programs a span level no larger than the detectable range.
// RULE_11: for electrochemical cells the third special register gives the 0-15 gain code.
// RULE_12: catalytic gas and calibration factors are read/write and limited to 79-565.
// RULE_13: the infrared gas factor is read/write and limited to 20-565.
// RULE_14: the four special registers change meaning with the sensor-type code 1 to 5.
// RULE_15: heated-film mode shows heater power (r/w), voltage, resistance and current.
// RULE_16: electrochemical register two has polarity on top and bias low; four gives raw counts.
`timescale 1ns/1ns
`default_nettype none
module ssv_special_view
    import ssv_pkg::*;
#(
    parameter longint CYCLES_PER_DAY = DAY_CYCLES
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous reset
    input wire logic [15:0] reg_addr, // register number
    input wire logic reg_rd, // read strobe
    input wire logic reg_wr, // write strobe
    input wire logic [15:0] reg_wdata, // write data
    output logic [15:0] reg_rdata, // read data
    output logic reg_ack, // answer strobe
    output logic reg_err, // refused access
    input wire logic [1:0] units_sel, // ppm, ppb or percent
    input wire logic gas_name_we, // gas name load strobe
    input wire logic [1:0] gas_name_addr, // gas name word
    input wire logic [15:0] gas_name_data, // two gas name characters
    input wire logic [15:0] gas_value, // measured gas value
    input wire logic [3:0] fault_cond, // live fault conditions
    input wire logic span_cal_done, // span calibration succeeded
    input wire logic cell_polarity_pos, // cell polarity positive
    input wire logic [11:0] cell_bias_mv, // cell bias
    input wire logic [3:0] amp_gain, // amplifier gain code
    input wire logic [15:0] raw_counts, // raw converter counts
    input wire logic [15:0] bridge_ma, // bridge current
    input wire logic [15:0] bridge_mv, // bridge voltage
    input wire logic [15:0] active_counts, // infrared active counts
    input wire logic [15:0] ref_counts, // infrared reference counts
    input wire logic [15:0] range_div, // infrared range divisor
    input wire logic [15:0] heater_mv, // heater voltage
    input wire logic [15:0] sensor_res, // sensor resistance, x100 ohm
    input wire logic [15:0] heater_ma, // heater current
    output logic [15:0] heater_power, // heater power setting
    output logic [15:0] sensor_type, // sensor type code
    output logic cal_overdue // calibration overdue fault
);
    // ****************************************
    // state
    // ****************************************
    logic [15:0] range_reg, range_next;
    logic [15:0] type_reg, type_next;
    logic [15:0] low_range_reg, low_range_next;
    logic [15:0] cat_gas_reg, cat_gas_next;
    logic [15:0] cat_cal_reg, cat_cal_next;
    logic [15:0] infra_gas_reg, infra_gas_next;
    logic [15:0] heater_power_next;
    logic [15:0] reading_reg, reading_next;
    logic [4:0] fault_reg, fault_next;
    logic [43:0] cyc_reg, cyc_next;
    logic [7:0] days_reg, days_next;
    logic cal_overdue_next;
    logic rd_q_reg, rd_q_next;
    logic ack_q_reg, ack_q_next;
    logic err_q_reg, err_q_next;
    logic [15:0] addr_q_reg, addr_q_next;
    logic [15:0] rdata_next;
    logic ack_next, err_next;
    logic [15:0] mem_rdata;
    logic [1:0] mem_raddr;
    logic [2:0] text_idx;
    logic [22:0] product;
    logic [6:0] scale;
    logic ec_like, wr_ok;
    logic [15:0] sp1, sp2, sp3, sp4;
    logic [7:0] unit1, unit2, unit3;

    ssv_text_mem u_text (
        .clk(clk),
        .reset(reset),
        .we(gas_name_we),
        .waddr(gas_name_addr),
        .wdata(gas_name_data),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // ****************************************
    // next values
    // ****************************************
    always_comb begin
        ec_like = (type_reg == ELECTROCHEMICAL_CELL_TYPE)
            || (type_reg == PHOTOIONISATION_CELL_TYPE);
        mem_raddr = 2'((reg_addr - ADDR_TEXT_FIRST) - 16'(TEXT_GAS_FIRST));
        text_idx = 3'(addr_q_reg - ADDR_TEXT_FIRST);
        // units code, then the space terminator
        case (units_sel) // RULE_01
            UNITS_PPM: begin
                unit1 = CHAR_P;
                unit2 = CHAR_P;
                unit3 = CHAR_M;
            end
            UNITS_PPB: begin
                unit1 = CHAR_P;
                unit2 = CHAR_P;
                unit3 = CHAR_B;
            end
            default: begin
                unit1 = CHAR_SPACE;
                unit2 = CHAR_SPACE;
                unit3 = CHAR_PCT;
            end
        endcase
        // special register meaning per cell type
        case (type_reg) // RULE_14
            ELECTROCHEMICAL_CELL_TYPE, PHOTOIONISATION_CELL_TYPE: begin
                sp1 = low_range_reg;
                sp2 = {cell_polarity_pos, 3'h0, cell_bias_mv}; // RULE_16
                sp3 = {12'h000, amp_gain}; // RULE_11
                sp4 = raw_counts; // RULE_16
            end
            CATALYTIC_CELL_TYPE: begin
                sp1 = cat_gas_reg; // RULE_12
                sp2 = cat_cal_reg; // RULE_12
                sp3 = bridge_ma;
                sp4 = bridge_mv;
            end
            INFRARED_CELL_TYPE: begin
                sp1 = infra_gas_reg; // RULE_13
                sp2 = active_counts;
                sp3 = ref_counts;
                sp4 = range_div;
            end
            HEATED_FILM_CELL_TYPE: begin
                sp1 = heater_power; // RULE_15
                sp2 = heater_mv; // RULE_15
                sp3 = sensor_res; // RULE_15
                sp4 = heater_ma; // RULE_15
            end
            default: begin
                sp1 = 16'h0000;
                sp2 = 16'h0000;
                sp3 = 16'h0000;
                sp4 = 16'h0000;
            end
        endcase
        // register writes, refused when out of limits
        range_next = range_reg;
        type_next = type_reg;
        low_range_next = low_range_reg;
        cat_gas_next = cat_gas_reg;
        cat_cal_next = cat_cal_reg;
        infra_gas_next = infra_gas_reg;
        heater_power_next = heater_power;
        wr_ok = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_RANGE: begin
                    wr_ok = (reg_wdata == RANGE_A) || (reg_wdata == RANGE_B)
                        || (reg_wdata == RANGE_C) || (reg_wdata == RANGE_D); // RULE_07
                    if (wr_ok) begin
                        range_next = reg_wdata;
                    end
                end
                ADDR_SENSOR_TYPE: begin
                    wr_ok = (reg_wdata >= ELECTROCHEMICAL_CELL_TYPE)
                        && (reg_wdata <= PHOTOIONISATION_CELL_TYPE);
                    if (wr_ok) begin
                        type_next = reg_wdata;
                    end
                end
                ADDR_SPECIAL_ONE: begin
                    if (ec_like) begin
                        wr_ok = reg_wdata <= LOW_RANGE_MAX;
                        if (wr_ok) begin
                            low_range_next = reg_wdata;
                        end
                    end else if (type_reg == CATALYTIC_CELL_TYPE) begin
                        wr_ok = (reg_wdata >= CAT_FACTOR_MIN) && (reg_wdata <= FACTOR_MAX);
                        if (wr_ok) begin
                            cat_gas_next = reg_wdata; // RULE_12
                        end
                    end else if (type_reg == INFRARED_CELL_TYPE) begin
                        wr_ok = (reg_wdata >= INFRA_FACTOR_MIN) && (reg_wdata <= FACTOR_MAX);
                        if (wr_ok) begin
                            infra_gas_next = reg_wdata; // RULE_13
                        end
                    end else begin
                        wr_ok = 1'b1;
                        heater_power_next = reg_wdata; // RULE_15
                    end
                end
                ADDR_SPECIAL_TWO: begin
                    wr_ok = (type_reg == CATALYTIC_CELL_TYPE)
                        && (reg_wdata >= CAT_FACTOR_MIN) && (reg_wdata <= FACTOR_MAX);
                    if (wr_ok) begin
                        cat_cal_next = reg_wdata; // RULE_12
                    end
                end
                default: wr_ok = 1'b0;
            endcase
        end
        // reading scaled by the low-range code, unit from the string
        case (low_range_reg[1:0]) // RULE_06 RULE_05
            2'h1: scale = SCALE_X10;
            2'h2: scale = SCALE_X100;
            default: scale = SCALE_X1;
        endcase
        product = 23'(gas_value) * 23'(scale);
        reading_next = (product[22:16] != 7'h00) ? 16'hffff : product[15:0];
        // status follows live conditions
        cyc_next = cyc_reg;
        days_next = days_reg;
        if (span_cal_done) begin
            cyc_next = 44'h0; // RULE_09
            days_next = 8'h00;
        end else if (days_reg < OVERDUE_DAYS) begin
            if (cyc_reg >= 44'(CYCLES_PER_DAY - 1)) begin
                cyc_next = 44'h0;
                days_next = days_reg + 8'h01;
            end else begin
                cyc_next = cyc_reg + 44'h1;
            end
        end
        cal_overdue_next = days_next >= OVERDUE_DAYS; // RULE_09
        fault_next = {cal_overdue_next, fault_cond}; // RULE_08
        // request pipeline, answer two edges after the strobe
        rd_q_next = reg_rd;
        ack_q_next = reg_rd || reg_wr;
        err_q_next = reg_wr && !wr_ok;
        addr_q_next = reg_addr;
        ack_next = ack_q_reg;
        err_next = err_q_reg;
        rdata_next = 16'h0000;
        if (rd_q_reg) begin
            case (addr_q_reg)
                ADDR_RANGE: rdata_next = range_reg;
                ADDR_READING: rdata_next = reading_reg;
                ADDR_FAULT: rdata_next = {11'h000, fault_reg};
                ADDR_SENSOR_TYPE: rdata_next = type_reg;
                ADDR_SPECIAL_ONE: rdata_next = sp1;
                ADDR_SPECIAL_TWO: rdata_next = sp2;
                ADDR_SPECIAL_THREE: rdata_next = sp3;
                ADDR_SPECIAL_FOUR: rdata_next = sp4;
                default: begin
                    if (addr_q_reg >= ADDR_TEXT_FIRST && addr_q_reg <= ADDR_TEXT_LAST) begin
                        case (text_idx) // RULE_04
                            3'h0: rdata_next = {unit2, unit1};
                            3'h1: rdata_next = {CHAR_SPACE, unit3}; // RULE_01
                            3'h2, 3'h3, 3'h4: rdata_next = mem_rdata; // RULE_02
                            default: rdata_next = {CHAR_NULL, CHAR_NULL}; // RULE_03
                        endcase
                    end else begin
                        err_next = 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            range_reg <= RESET_RANGE;
            type_reg <= RESET_SENSOR_TYPE;
            low_range_reg <= RESET_LOW_RANGE;
            cat_gas_reg <= RESET_FACTOR;
            cat_cal_reg <= RESET_FACTOR;
            infra_gas_reg <= RESET_FACTOR;
            heater_power <= RESET_HEATER_POWER;
            reading_reg <= 16'h0000;
            fault_reg <= 5'h00;
            cyc_reg <= 44'h0;
            days_reg <= 8'h00;
            cal_overdue <= 1'b0;
            rd_q_reg <= 1'b0;
            ack_q_reg <= 1'b0;
            err_q_reg <= 1'b0;
            addr_q_reg <= 16'h0000;
            reg_rdata <= 16'h0000;
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
            sensor_type <= RESET_SENSOR_TYPE;
        end else begin
            range_reg <= range_next;
            type_reg <= type_next;
            low_range_reg <= low_range_next;
            cat_gas_reg <= cat_gas_next;
            cat_cal_reg <= cat_cal_next;
            infra_gas_reg <= infra_gas_next;
            heater_power <= heater_power_next;
            reading_reg <= reading_next;
            fault_reg <= fault_next;
            cyc_reg <= cyc_next;
            days_reg <= days_next;
            cal_overdue <= cal_overdue_next;
            rd_q_reg <= rd_q_next;
            ack_q_reg <= ack_q_next;
            err_q_reg <= err_q_next;
            addr_q_reg <= addr_q_next;
            reg_rdata <= rdata_next;
            reg_ack <= ack_next;
            reg_err <= err_next;
            sensor_type <= type_next;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    range_legal_a: assert property (@(posedge clk) disable iff (reset) // RULE_07
        range_reg == RANGE_A || range_reg == RANGE_B || range_reg == RANGE_C
            || range_reg == RANGE_D)
        else $error("range register holds an illegal value");
    reading_x10_a: assert property (@(posedge clk) disable iff (reset) // RULE_06
        (low_range_reg == 16'h0001 && gas_value < 16'h0fff)
            |=> reading_reg == 16'($past(gas_value) * 16'h000a))
        else $error("reading not scaled by ten");
    reading_x100_a: assert property (@(posedge clk) disable iff (reset) // RULE_06
        (low_range_reg == 16'h0002 && gas_value < 16'h00ff)
            |=> reading_reg == 16'($past(gas_value) * 16'h0064))
        else $error("reading not scaled by one hundred");
    fault_follow_a: assert property (@(posedge clk) disable iff (reset) // RULE_08
        ##1 fault_reg[3:0] == $past(fault_cond))
        else $error("fault bits do not follow conditions");
    overdue_clear_a: assert property (@(posedge clk) disable iff (reset) // RULE_09
        span_cal_done |=> !cal_overdue && days_reg == 8'h00)
        else $error("calibration did not restart the overdue timer");
    overdue_days_a: assert property (@(posedge clk) disable iff (reset) // RULE_09
        cal_overdue == (days_reg >= OVERDUE_DAYS))
        else $error("overdue flag disagrees with day count");
    text_term_a: assert property (@(posedge clk) disable iff (reset) // RULE_01
        (reg_rd && reg_addr == 16'h9c51) |-> ##2 reg_ack && reg_rdata[15:8] == CHAR_SPACE)
        else $error("units field not ended by a space");
    text_null_a: assert property (@(posedge clk) disable iff (reset) // RULE_03
        (reg_rd && reg_addr == ADDR_TEXT_LAST) |-> ##2 reg_ack && reg_rdata == 16'h0000)
        else $error("notation string not null ended");
    cat_limits_a: assert property (@(posedge clk) disable iff (reset) // RULE_12
        cat_gas_reg >= CAT_FACTOR_MIN && cat_gas_reg <= FACTOR_MAX
            && cat_cal_reg >= CAT_FACTOR_MIN && cat_cal_reg <= FACTOR_MAX)
        else $error("catalytic factor out of limits");
    infra_limits_a: assert property (@(posedge clk) disable iff (reset) // RULE_13
        infra_gas_reg >= INFRA_FACTOR_MIN && infra_gas_reg <= FACTOR_MAX)
        else $error("infrared factor out of limits");
    gain_view_a: assert property (@(posedge clk) disable iff (reset) // RULE_11
        (reg_rd && reg_addr == ADDR_SPECIAL_THREE && type_reg == ELECTROCHEMICAL_CELL_TYPE
            && !reg_wr) ##1 $stable(amp_gain) |=> reg_rdata == {12'h000, $past(amp_gain)})
        else $error("gain code not shown in third special register");
endmodule
`default_nettype wire

// ===== ssv_pkg.sv
// shared constants for the sensor special register view
package ssv_pkg;
    // ****************************************
    // register numbers
    // ****************************************
    localparam logic [15:0] ADDR_RANGE = 16'h9c41;
    localparam logic [15:0] ADDR_READING = 16'h9c42;
    localparam logic [15:0] ADDR_FAULT = 16'h9c43;
    localparam logic [15:0] ADDR_SENSOR_TYPE = 16'h9c46;
    localparam logic [15:0] ADDR_SPECIAL_ONE = 16'h9c4b;
    localparam logic [15:0] ADDR_SPECIAL_TWO = 16'h9c4c;
    localparam logic [15:0] ADDR_SPECIAL_THREE = 16'h9c4d;
    localparam logic [15:0] ADDR_SPECIAL_FOUR = 16'h9c4e;
    localparam logic [15:0] ADDR_TEXT_FIRST = 16'h9c50;
    localparam logic [15:0] ADDR_TEXT_LAST = 16'h9c55;
    // ****************************************
    // text layout
    // ****************************************
    localparam logic [7:0] CHAR_SPACE = 8'h20;
    localparam logic [7:0] CHAR_NULL = 8'h00;
    localparam logic [7:0] CHAR_P = 8'h50;
    localparam logic [7:0] CHAR_M = 8'h4d;
    localparam logic [7:0] CHAR_B = 8'h42;
    localparam logic [7:0] CHAR_PCT = 8'h25;
    localparam logic [1:0] UNITS_PPM = 2'h0;
    localparam logic [1:0] UNITS_PPB = 2'h1;
    localparam logic [2:0] TEXT_GAS_FIRST = 3'h2;
    localparam logic [2:0] TEXT_GAS_LAST = 3'h4;
    // ****************************************
    // sensor type codes
    // ****************************************
    localparam logic [15:0] ELECTROCHEMICAL_CELL_TYPE = 16'h0001;
    localparam logic [15:0] CATALYTIC_CELL_TYPE = 16'h0002;
    localparam logic [15:0] INFRARED_CELL_TYPE = 16'h0003;
    localparam logic [15:0] HEATED_FILM_CELL_TYPE = 16'h0004;
    localparam logic [15:0] PHOTOIONISATION_CELL_TYPE = 16'h0005;
    // ****************************************
    // value limits and scaling
    // ****************************************
    localparam logic [15:0] CAT_FACTOR_MIN = 16'h004f;
    localparam logic [15:0] INFRA_FACTOR_MIN = 16'h0014;
    localparam logic [15:0] FACTOR_MAX = 16'h0235;
    localparam logic [15:0] LOW_RANGE_MAX = 16'h0002;
    localparam logic [15:0] RANGE_A = 16'h0014;
    localparam logic [15:0] RANGE_B = 16'h0032;
    localparam logic [15:0] RANGE_C = 16'h0064;
    localparam logic [15:0] RANGE_D = 16'h00c8;
    localparam logic [6:0] SCALE_X1 = 7'h01;
    localparam logic [6:0] SCALE_X10 = 7'h0a;
    localparam logic [6:0] SCALE_X100 = 7'h64;
    localparam logic [15:0] BIAS_MASK = 16'h0fff;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] RESET_RANGE = 16'h0014;
    localparam logic [15:0] RESET_SENSOR_TYPE = 16'h0004;
    localparam logic [15:0] RESET_LOW_RANGE = 16'h0000;
    localparam logic [15:0] RESET_FACTOR = 16'h0064;
    localparam logic [15:0] RESET_HEATER_POWER = 16'h0000;
    // ****************************************
    // timing
    // ****************************************
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint DAY_SECONDS = 86400;
    localparam longint DAY_CYCLES = DAY_SECONDS * 1000000000 / CLK_PERIOD_NS;
    localparam logic [7:0] OVERDUE_DAYS = 8'hb4;
endpackage

// ===== ssv_text_mem.sv
// small memory holding the gas name words of the notation string
`timescale 1ns/1ns
`default_nettype none
module ssv_text_mem (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous reset
    input wire logic we, // write strobe
    input wire logic [1:0] waddr, // write word
    input wire logic [15:0] wdata, // two characters, earlier one low
    input wire logic [1:0] raddr, // read word
    output logic [15:0] rdata // registered read data
);
    logic [15:0] mem_reg [3];
    logic [15:0] mem_next [3];
    logic [15:0] rdata_next;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (we && waddr < 2'h3) begin
            mem_next[waddr] = wdata;
        end
        rdata_next = (raddr < 2'h3) ? mem_reg[raddr] : 16'h0000;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                mem_reg[i] <= 16'h2020;
            end
            rdata <= 16'h0000;
        end else begin
            mem_reg <= mem_next;
            rdata <= rdata_next;
        end
    end
endmodule
`default_nettype wire

// ===== ssv_master_model.sv
// bus master model that polls and writes the register port
`timescale 1ns/1ns
`default_nettype none
module ssv_master_model (
    input wire logic clk, // system clock
    output logic [15:0] reg_addr, // register number
    output logic reg_rd, // read strobe
    output logic reg_wr, // write strobe
    output logic [15:0] reg_wdata, // write data
    input wire logic [15:0] reg_rdata, // read data
    input wire logic reg_ack, // answer strobe
    input wire logic reg_err // refused access
);
    initial begin
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
    end
    // one-cycle strobe, address held until the answer
    task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] q,
        output logic e);
        @(posedge clk);
        reg_rd <= ~w;
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        for (int n = 0; n < 8 && reg_ack !== 1'b1; n++) @(posedge clk);
        // a missing answer shows as unknown so that every compare fails
        q = (reg_ack === 1'b1) ? reg_rdata : 16'hxxxx;
        e = (reg_ack === 1'b1) ? reg_err : 1'bx;
        // released lines show the inverse value
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== sensor_special_register_view_tb.sv
// self-checking bench for the sensor special register view
`timescale 1ns/1ns
`default_nettype none
module sensor_special_register_view_tb;
    import ssv_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, heater_power, sensor_type;
    logic reg_rd, reg_wr, reg_ack, reg_err, cal_overdue;
    logic [1:0] units_sel = 2'h0;
    logic [1:0] gas_name_addr = 2'h0;
    logic gas_name_we = 1'b0;
    logic span_cal_done = 1'b0;
    logic cell_polarity_pos = 1'b1;
    logic [11:0] cell_bias_mv = 12'h096;
    logic [3:0] amp_gain = 4'hf;
    logic [3:0] fault_cond = 4'h0;
    logic [15:0] gas_name_data = 16'h0000, gas_value = 16'h007b, raw_counts = 16'h8001;
    logic [15:0] bridge_ma = 16'h2202, bridge_mv = 16'h3303, active_counts = 16'h4404;
    logic [15:0] ref_counts = 16'h5505, range_div = 16'h0064, heater_mv = 16'h7707;
    logic [15:0] sensor_res = 16'h8808, heater_ma = 16'h9909;
    localparam logic [15:0] GN [3] = '{16'h3248, 16'h7e01, 16'h2153};
    localparam logic [15:0] TW [6] = '{16'h5050, 16'h204d, 16'h5050, 16'h2042, 16'h2020, 16'h2025};
    localparam logic [63:0] ROW [22] = '{
        64'h9c46_0000_0001_0005, 64'h9c46_0006_0001_0005, 64'h9c41_0032_0000_0032,
        64'h9c41_00c8_0000_00c8, 64'h9c41_001e_0001_00c8, 64'h9c41_0064_0000_0064,
        64'h9c46_0002_0000_0002, 64'h9c4b_004e_0001_0064, 64'h9c4b_0235_0000_0235,
        64'h9c4b_0236_0001_0235, 64'h9c4c_004f_0000_004f, 64'h9c4c_0236_0001_004f,
        64'h9c46_0003_0000_0003, 64'h9c4b_0013_0001_0064, 64'h9c4b_0014_0000_0014,
        64'h9c4d_0000_0001_5505, 64'h9c46_0004_0000_0004, 64'h9c4b_00eb_0000_00eb,
        64'h9c46_0001_0000_0001, 64'h9c4b_0003_0001_0000, 64'h9c4b_0002_0000_0002,
        64'h9c42_0000_0001_300c};
    int fail_count = 0;
    int samples_checked = 0;
    ssv_special_view #(.CYCLES_PER_DAY(4)) uut (.*);
    ssv_master_model m (.*);
    always #5 clk = ~clk;
    function automatic logic [15:0] spec(input int t, input int i);
        logic [15:0] v [4];
        case (t)
            2: v = '{RESET_FACTOR, RESET_FACTOR, bridge_ma, bridge_mv};
            3: v = '{RESET_FACTOR, active_counts, ref_counts, range_div};
            4: v = '{16'h0000, heater_mv, sensor_res, heater_ma};
            default: v = '{16'h0000, 16'h8096, 16'h000f, raw_counts};
        endcase
        return v[i];
    endfunction
    task automatic check(input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, d, ed, input logic ee);
        logic [15:0] q;
        logic e;
        m.xfer(w, a, d, q, e);
        check(q, ed);
        check({15'h0000, e}, {15'h0000, ee});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        check(sensor_type, RESET_SENSOR_TYPE);
        check(heater_power, 16'h0000);
        repeat (710) @(posedge clk);
        check({15'h0000, cal_overdue}, 16'h0000);
        repeat (30) @(posedge clk);
        check({15'h0000, cal_overdue}, 16'h0001);
        acc(0, ADDR_FAULT, 16'h0000, 16'h0010, 0);
        span_cal_done <= 1'b1;
        @(posedge clk);
        span_cal_done <= 1'b0;
        fault_cond <= 4'ha;
        acc(0, ADDR_FAULT, 16'h0000, 16'h000a, 0);
        fault_cond <= 4'h0;
        acc(0, ADDR_FAULT, 16'h0000, 16'h0000, 0);
        for (int u = 0; u < 3; u++) begin
            units_sel <= u[1:0];
            acc(0, ADDR_TEXT_FIRST, 16'h0000, TW[2 * u], 0);
            acc(0, ADDR_TEXT_FIRST + 16'h0001, 16'h0000, TW[2 * u + 1], 0);
        end
        for (int k = 0; k < 3; k++) begin
            gas_name_we <= 1'b1;
            gas_name_addr <= k[1:0];
            gas_name_data <= GN[k];
            @(posedge clk);
        end
        gas_name_we <= 1'b0;
        for (int k = 0; k < 3; k++) acc(0, ADDR_TEXT_FIRST + 16'(k + 2), 16'h0000, GN[k], 0);
        acc(0, ADDR_TEXT_LAST, 16'h0000, 16'h0000, 0);
        acc(1, ADDR_TEXT_FIRST, 16'h4141, 16'h0000, 1);
        acc(0, 16'h0000, 16'h0000, 16'h0000, 1);
        for (int t = 1; t < 6; t++) begin
            acc(1, ADDR_SENSOR_TYPE, 16'(t), 16'h0000, 0);
            check(sensor_type, 16'(t));
            for (int i = 0; i < 4; i++) acc(0, ADDR_SPECIAL_ONE + 16'(i), 16'h0000, spec(t, i), 0);
        end
        for (int r = 0; r < 22; r++) begin
            acc(1, ROW[r][63:48], ROW[r][47:32], 16'h0000, ROW[r][16]);
            acc(0, ROW[r][63:48], 16'h0000, ROW[r][15:0], 0);
        end
        acc(1, ADDR_SPECIAL_ONE, 16'h0001, 16'h0000, 0);
        acc(0, ADDR_READING, 16'h0000, 16'h04ce, 0);
        acc(1, ADDR_SPECIAL_ONE, 16'h0000, 16'h0000, 0);
        acc(0, ADDR_READING, 16'h0000, 16'h007b, 0);
        check(heater_power, 16'h00eb);
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
